//--- aod_top.sv
// Analog output mode decoding and diagnostic record keeping.
// Assumes parameters come from logic on i_mclk; field pins are async.
//
// Overview of operation
// - Type nibble 0001b selects voltage output.
// - Type nibble 0010b selects current output.
// - Voltage ranges: 1000b 0-10V, 0111b 1-5V, 1001b bipolar 10V.
// - Current ranges: 0010b 0-20mA, 0011b 4-20mA, 0100b bipolar 20mA.
// - Word 27648 is nominal top; words up to 32511 are overdrive.
// - Live-zero ranges end underdrive at -6912, meaning zero output.
// - Bipolar ranges span -27648..27648, underdrive ends at -32512.
// - With group diagnostics on, errors are recorded for host reading.
// - With interrupt enabled, coming and going errors interrupt; lamps show.
// - No diagnostic interrupt unless its enable is set.
// - Detect wire break, ground short, front switch, supply loss, bad mode.
// - Report starts when an error appears and again when it clears.
// - With interrupt enabled, record 0 is offered on each error.
// - Record 1 stays readable during operation.
// - Diagnostic data stays frozen until the handler is left.
// - Byte 0 bits 0,2,3,4,7 flag errors; resets to 00h.
// - Byte 1 holds class 0101 and channel-info bit, reading 15h.
// - Byte 2 bit 2 shows stop; byte 3 is unused.
// - Record 1 is record 0 plus eight module-specific bytes.
// - Mode byte: range in bits 3..0, type in bits 7..4.
// - Mode byte 00h deactivates the channel.
`timescale 1ns/1ns
module aod_top
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Channel parameters
	input wire logic [aod_pkg::NUM_CH-1:0][7:0] i_mode,
	input wire logic [aod_pkg::NUM_CH-1:0][15:0] i_out_word,
	input wire logic [aod_pkg::NUM_CH-1:0] i_grp_diag_en,
	input wire logic i_diag_irq_en,
	// Field conditions, asynchronous
	input wire logic [aod_pkg::NUM_CH-1:0] i_wire_break,
	input wire logic [aod_pkg::NUM_CH-1:0] i_gnd_short,
	input wire logic [aod_pkg::NUM_CH-1:0] i_front_manual,
	input wire logic i_supply_lost,
	input wire logic i_cpu_stop,
	// Record read port
	input wire logic i_rd_en,
	input wire logic i_rd_rec,
	input wire logic [3:0] i_rd_addr,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	// Diagnostic interrupt
	input wire logic i_irq_done,
	output logic o_irq,
	output logic o_irq_going,
	// Output stage
	output logic [aod_pkg::NUM_CH-1:0][15:0] o_dac_word,
	output logic [aod_pkg::NUM_CH-1:0] o_out_current,
	output logic [aod_pkg::NUM_CH-1:0] o_out_active,
	// Indicator lamps
	output logic o_led_group,
	output logic [aod_pkg::NUM_CH-1:0] o_led_chan
);
	import aod_pkg::*;

	localparam int SW = 3 * NUM_CH + 2;

	typedef struct packed {
		logic [SW-1:0] sync1;
		logic [SW-1:0] sync2;
		logic [NUM_CH-1:0][7:0] cs;
		logic supply;
		logic stop;
		logic irq;
		logic going;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [NUM_CH-1:0][15:0] dac;
		logic [NUM_CH-1:0] cur;
		logic [NUM_CH-1:0] act;
		logic led_grp;
		logic [NUM_CH-1:0] led_ch;
	} aod_state_s;

	aod_state_s st;
	aod_state_s next_st;

	aod_ch_if ch_if [NUM_CH] ();

	logic [NUM_CH-1:0] perr;
	logic [NUM_CH-1:0][15:0] dac_w;
	logic [NUM_CH-1:0] cur_w;
	logic [NUM_CH-1:0] act_w;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			assign ch_if[g].mode = i_mode[g];
			assign ch_if[g].word = i_out_word[g];
			assign dac_w[g] = ch_if[g].dac;
			assign cur_w[g] = ch_if[g].is_current;
			assign act_w[g] = ch_if[g].active;
			assign perr[g] = ch_if[g].param_err;
			aod_chan u_chan
			(
				.ch (ch_if[g])
			);
		end
	endgenerate

	// Synchronised field levels
	logic [NUM_CH-1:0] s_wire;
	logic [NUM_CH-1:0] s_short;
	logic [NUM_CH-1:0] s_sw;
	logic s_supply;
	logic s_stop;

	assign s_wire = st.sync2[NUM_CH-1:0];
	assign s_short = st.sync2[2*NUM_CH-1:NUM_CH];
	assign s_sw = st.sync2[3*NUM_CH-1:2*NUM_CH];
	assign s_supply = st.sync2[SW-2];
	assign s_stop = st.sync2[SW-1];

	// Live error picture, gated by group diagnostics
	logic [NUM_CH-1:0][7:0] live_cs;
	logic live_supply;
	logic err_chg;
	logic err_new;

	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			live_cs[c] = 8'h00;
			if (i_grp_diag_en[c])
			begin
				live_cs[c][CS_PARAM] = perr[c];
				live_cs[c][CS_SHORT] = s_short[c];
				live_cs[c][CS_WIRE] = s_wire[c];
				live_cs[c][CS_SWITCH] = s_sw[c];
			end
		end
		live_supply = s_supply && (|i_grp_diag_en);
		err_chg = (live_cs != st.cs) || (live_supply != st.supply);
		err_new = (|(live_cs & ~st.cs)) || (live_supply && !st.supply);
	end

	// Record bytes built from the frozen snapshot
	logic [NUM_CH-1:0] ch_err;
	logic any_param;
	logic any_ext;
	logic [7:0] rec0 [4];
	logic [7:0] rec1_hi [8];

	always_comb
	begin
		any_param = 1'b0;
		any_ext = st.supply;
		for (int c = 0; c < NUM_CH; c++)
		begin
			ch_err[c] = |st.cs[c];
			any_param = any_param | st.cs[c][CS_PARAM];
			any_ext = any_ext | st.cs[c][CS_SHORT] | st.cs[c][CS_WIRE] |
				st.cs[c][CS_SWITCH];
		end
		rec0[0] = ERR_RST;
		rec0[0][ERR_MODULE] = (|ch_err) | st.supply;
		rec0[0][ERR_EXT] = any_ext;
		rec0[0][ERR_CHAN] = |ch_err;
		rec0[0][ERR_SUPPLY] = st.supply;
		rec0[0][ERR_PARAM] = any_param;
		rec0[1] = CLASS_INFO;
		rec0[2] = 8'h00;
		rec0[2][STATE_STOP] = st.stop;
		rec0[3] = 8'h00;
		rec1_hi[0] = CHTYPE_INFO;
		rec1_hi[1] = DIAG_BITS;
		rec1_hi[2] = NCH_INFO;
		rec1_hi[3] = {{(8 - NUM_CH){1'b0}}, ch_err};
		for (int c = 0; c < NUM_CH; c++)
			rec1_hi[CS_BASE - 4 + c] = st.cs[c];
	end

	logic [7:0] rec0_sel;
	assign rec0_sel = rec0[i_rd_addr[1:0]];

	always_comb
	begin
		next_st = st;
		next_st.sync1 = {i_cpu_stop, i_supply_lost, i_front_manual,
			i_gnd_short, i_wire_break};
		next_st.sync2 = st.sync1;
		next_st.dac = dac_w;
		next_st.cur = cur_w;
		next_st.act = act_w;
		next_st.rd_valid = i_rd_en;
		if (i_rd_en)
		begin
			if (i_rd_addr < 4'h4)
				next_st.rd_data = rec0_sel;
			else if (i_rd_rec && i_rd_addr < 4'hc)
				next_st.rd_data = rec1_hi[i_rd_addr[2:0] - 3'h4];
			else
				next_st.rd_data = 8'h00;
		end
		if (st.irq)
		begin
			if (i_irq_done)
				next_st.irq = 1'b0;
		end
		else
		begin
			next_st.stop = s_stop;
			if (err_chg)
			begin
				next_st.cs = live_cs;
				next_st.supply = live_supply;
				if (i_diag_irq_en)
				begin
					next_st.irq = 1'b1;
					next_st.going = !err_new;
				end
			end
		end
		next_st.led_grp = rec0[0][ERR_MODULE];
		next_st.led_ch = ch_err;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_rd_data = st.rd_data;
	assign o_rd_valid = st.rd_valid;
	assign o_irq = st.irq;
	assign o_irq_going = st.going;
	assign o_dac_word = st.dac;
	assign o_out_current = st.cur;
	assign o_out_active = st.act;
	assign o_led_group = st.led_grp;
	assign o_led_chan = st.led_ch;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_err_event;
		!st.irq && i_diag_irq_en && err_chg;
	endsequence

	sequence s_irq_held;
		st.irq && !i_irq_done;
	endsequence

	property p_volt_type;
		i_mode[0][7:4] == TYPE_VOLT && i_mode[0][3:0] == RNG_V_0_10
			|=> !o_out_current[0] && o_out_active[0];
	endproperty
	a_volt_type: assert property (p_volt_type)
		else $error("voltage type not decoded");

	property p_curr_type;
		i_mode[0][7:4] == TYPE_CURR && i_mode[0][3:0] == RNG_I_4_20
			|=> o_out_current[0] && o_out_active[0];
	endproperty
	a_curr_type: assert property (p_curr_type)
		else $error("current type not decoded");

	property p_bad_range;
		i_mode[1] == {TYPE_VOLT, RNG_I_0_20}
			|=> !o_out_active[1] && o_dac_word[1] == WORD_ZERO;
	endproperty
	a_bad_range: assert property (p_bad_range)
		else $error("illegal voltage range accepted");

	property p_curr_bip;
		i_mode[1] == {TYPE_CURR, RNG_I_BIP} &&
			$signed(i_out_word[1]) < WORD_NOM_LO_BIP
			|=> $signed(o_dac_word[1]) < WORD_ZERO;
	endproperty
	a_curr_bip: assert property (p_curr_bip)
		else $error("bipolar current range lost sign");

	property p_over_clamp;
		i_mode[0] != MODE_OFF && o_out_active[0] &&
			$signed(i_out_word[0]) > WORD_OVER_END
			|=> o_dac_word[0] == WORD_OVER_END;
	endproperty
	a_over_clamp: assert property (p_over_clamp)
		else $error("overdrive not limited at 32511");

	property p_nominal_pass;
		i_mode[2] == {TYPE_VOLT, RNG_V_0_10} && i_out_word[2] == WORD_NOM_HI
			|=> o_dac_word[2] == WORD_NOM_HI;
	endproperty
	a_nominal_pass: assert property (p_nominal_pass)
		else $error("nominal top word altered");

	property p_live0_clamp;
		i_mode[0] == {TYPE_VOLT, RNG_V_1_5} &&
			$signed(i_out_word[0]) < WORD_UNDER_LIVE0
			|=> o_dac_word[0] == WORD_UNDER_LIVE0;
	endproperty
	a_live0_clamp: assert property (p_live0_clamp)
		else $error("live-zero underdrive not limited at -6912");

	property p_bip_clamp;
		i_mode[3] == {TYPE_VOLT, RNG_V_BIP} &&
			$signed(i_out_word[3]) < WORD_UNDER_BIP
			|=> o_dac_word[3] == WORD_UNDER_BIP;
	endproperty
	a_bip_clamp: assert property (p_bip_clamp)
		else $error("bipolar underdrive not limited at -32512");

	property p_record;
		!st.irq && err_chg |=> st.cs == $past(live_cs);
	endproperty
	a_record: assert property (p_record)
		else $error("error not recorded");

	property p_irq_raise;
		s_err_event |=> o_irq ##0 o_irq_going == !$past(err_new);
	endproperty
	a_irq_raise: assert property (p_irq_raise)
		else $error("diagnostic interrupt not raised");

	property p_no_irq;
		!st.irq && !i_diag_irq_en |=> !o_irq;
	endproperty
	a_no_irq: assert property (p_no_irq)
		else $error("interrupt without enable");

	property p_hold;
		s_irq_held |=> $stable(st.cs) && $stable(st.supply) && o_irq;
	endproperty
	a_hold: assert property (p_hold)
		else $error("diagnostic data changed inside handler");

	property p_release;
		st.irq && i_irq_done |=> !o_irq;
	endproperty
	a_release: assert property (p_release)
		else $error("interrupt not released");

	property p_class;
		i_rd_en && i_rd_addr == ADR_CLASS |=> o_rd_valid && o_rd_data == 8'h15;
	endproperty
	a_class: assert property (p_class)
		else $error("class byte wrong");

	property p_err_byte;
		i_rd_en && i_rd_addr == ADR_ERR
			|=> o_rd_data[1] == 1'b0 && o_rd_data[6:5] == 2'b00;
	endproperty
	a_err_byte: assert property (p_err_byte)
		else $error("reserved error bits set");

	property p_unused;
		i_rd_en && (i_rd_addr == ADR_UNUSED || i_rd_addr > 4'hb)
			|=> o_rd_data == 8'h00;
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused byte not zero");

	property p_rec1_head;
		i_rd_en && i_rd_rec && i_rd_addr == ADR_ERR
			|=> o_rd_data[ERR_CHAN] == ($past(st.cs) != '0) &&
			o_rd_data[ERR_SUPPLY] == $past(st.supply);
	endproperty
	a_rec1_head: assert property (p_rec1_head)
		else $error("record head differs from record 0");

	property p_off;
		i_mode[0] == MODE_OFF |=> o_dac_word[0] == WORD_ZERO && !o_out_active[0];
	endproperty
	a_off: assert property (p_off)
		else $error("deactivated channel drives output");

	property p_lamp;
		st.cs[0] != 8'h00 |=> o_led_chan[0];
	endproperty
	a_lamp: assert property (p_lamp)
		else $error("channel lamp dark on error");
endmodule // aod_top

//--- aod_pkg.sv
// Constants for the analog output mode decoder and diagnostic records.
// Assumes one clock domain; imported by aod_top and aod_chan, not by the interface.
package aod_pkg;
	localparam int NUM_CH = 4;
	localparam int CS_BASE = 8;

	// Mode byte: type in upper nibble, range in lower nibble
	localparam logic [7:0] MODE_OFF = 8'h00;
	localparam logic [3:0] TYPE_VOLT = 4'h1;
	localparam logic [3:0] TYPE_CURR = 4'h2;
	localparam logic [3:0] RNG_V_0_10 = 4'h8;
	localparam logic [3:0] RNG_V_1_5 = 4'h7;
	localparam logic [3:0] RNG_V_BIP = 4'h9;
	localparam logic [3:0] RNG_I_0_20 = 4'h2;
	localparam logic [3:0] RNG_I_4_20 = 4'h3;
	localparam logic [3:0] RNG_I_BIP = 4'h4;

	// Output word limits: 27648, 32511, -6912, -27648, -32512
	localparam logic signed [15:0] WORD_NOM_HI = 16'sh6c00;
	localparam logic signed [15:0] WORD_OVER_END = 16'sh7eff;
	localparam logic signed [15:0] WORD_UNDER_LIVE0 = 16'she500;
	localparam logic signed [15:0] WORD_NOM_LO_BIP = 16'sh9400;
	localparam logic signed [15:0] WORD_UNDER_BIP = 16'sh8100;
	localparam logic signed [15:0] WORD_ZERO = 16'sh0000;

	// Record byte addresses
	localparam logic [3:0] ADR_ERR = 4'h0;
	localparam logic [3:0] ADR_CLASS = 4'h1;
	localparam logic [3:0] ADR_STATE = 4'h2;
	localparam logic [3:0] ADR_UNUSED = 4'h3;
	localparam logic [3:0] ADR_CHTYPE = 4'h4;
	localparam logic [3:0] ADR_DIAGBITS = 4'h5;
	localparam logic [3:0] ADR_NCH = 4'h6;
	localparam logic [3:0] ADR_CHERR = 4'h7;

	// Bit positions and fixed values
	localparam int ERR_MODULE = 0;
	localparam int ERR_EXT = 2;
	localparam int ERR_CHAN = 3;
	localparam int ERR_SUPPLY = 4;
	localparam int ERR_PARAM = 7;
	localparam int STATE_STOP = 2;
	localparam int CS_PARAM = 0;
	localparam int CS_SHORT = 3;
	localparam int CS_WIRE = 4;
	localparam int CS_SWITCH = 5;
	localparam logic [7:0] ERR_RST = 8'h00;
	localparam logic [7:0] CLASS_INFO = 8'h15;
	localparam logic [7:0] CHTYPE_INFO = 8'h73;
	localparam logic [7:0] DIAG_BITS = 8'h08;
	localparam logic [7:0] NCH_INFO = 8'h04;

	typedef enum logic [1:0] {CLS_OFF, CLS_UNI, CLS_LIVE0, CLS_BIP} aod_cls_e;
endpackage

//--- aod_ch_if.sv
// Carrier between the top and one channel decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ns
interface aod_ch_if;
	logic [7:0] mode;
	logic signed [15:0] word;
	logic signed [15:0] dac;
	logic is_current;
	logic active;
	logic param_err;
	modport ctl (output mode, word, input dac, is_current, active, param_err);
	modport dec (input mode, word, output dac, is_current, active, param_err);
endinterface

//--- aod_chan.sv
// One channel: decodes the mode byte and limits the output word.
// Assumes the top registers dac, is_current and active; param_err feeds its error logic.
`timescale 1ns/1ns
module aod_chan
(
	// Channel link
	aod_ch_if.dec ch
);
	import aod_pkg::*;

	aod_cls_e cls;
	logic cur;
	logic perr;
	logic signed [15:0] lo;

	always_comb
	begin
		cls = CLS_OFF;
		cur = 1'b0;
		perr = 1'b0;
		if (ch.mode == MODE_OFF)
			cls = CLS_OFF;
		else if (ch.mode[7:4] == TYPE_VOLT)
		begin
			case (ch.mode[3:0])
				RNG_V_0_10: cls = CLS_UNI;
				RNG_V_1_5: cls = CLS_LIVE0;
				RNG_V_BIP: cls = CLS_BIP;
				default: perr = 1'b1;
			endcase
		end
		else if (ch.mode[7:4] == TYPE_CURR)
		begin
			cur = 1'b1;
			case (ch.mode[3:0])
				RNG_I_0_20: cls = CLS_UNI;
				RNG_I_4_20: cls = CLS_LIVE0;
				RNG_I_BIP: cls = CLS_BIP;
				default: perr = 1'b1;
			endcase
		end
		else
			perr = 1'b1;
		case (cls)
			CLS_LIVE0: lo = WORD_UNDER_LIVE0;
			CLS_BIP: lo = WORD_UNDER_BIP;
			default: lo = WORD_ZERO;
		endcase
		if (cls == CLS_OFF || perr)
			ch.dac = WORD_ZERO;
		else if (ch.word > WORD_OVER_END)
			ch.dac = WORD_OVER_END;
		else if (ch.word < lo)
			ch.dac = lo;
		else
			ch.dac = ch.word;
		ch.is_current = cur && !perr;
		ch.active = (cls != CLS_OFF) && !perr;
		ch.param_err = perr;
	end
endmodule // aod_chan

//--- aod_host_model.sv
// Host model: reads record bytes and runs the diagnostic handler.
// Assumes the device read port and irq/done handshake on one clock.
`timescale 1ns/1ns
module aod_host_model
#(
	parameter int HANDLER_CYCLES = 3
)
(
	// Clock and handler hold from the bench
	input wire logic i_mclk,
	input wire logic i_hold,
	// Device answers
	input wire logic i_irq,
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_data,
	// Requests to the device
	output logic o_rd_en,
	output logic o_rd_rec,
	output logic [3:0] o_rd_addr,
	output logic o_irq_done
);
	int cnt = 0;
	initial
	begin
		o_rd_en = 1'b0;
		o_rd_rec = 1'b0;
		o_rd_addr = 4'h0;
		o_irq_done = 1'b0;
	end
	// Released lines show the inverse of the last value
	task automatic rd(input logic rec, input logic [3:0] a,
		output logic [7:0] d, output logic v);
		@(posedge i_mclk);
		o_rd_en <= 1'b1;
		o_rd_rec <= rec;
		o_rd_addr <= a;
		@(posedge i_mclk);
		o_rd_en <= 1'b0;
		o_rd_rec <= ~rec;
		o_rd_addr <= ~a;
		#1;
		d = i_rd_data;
		v = i_rd_valid;
	endtask
	// Handler stays open while held, then ends after a delay
	always @(posedge i_mclk)
	begin
		o_irq_done <= 1'b0;
		if (i_irq && !i_hold && !o_irq_done)
		begin
			if (cnt >= HANDLER_CYCLES)
			begin
				o_irq_done <= 1'b1;
				cnt <= 0;
			end
			else
				cnt <= cnt + 1;
		end
	end
endmodule // aod_host_model

//--- analog_output_mode_and_diagnostics_tb.sv
// Testbench for the mode decoder and diagnostic records.
// Assumes the host model drives the read port and handler acknowledge.
`timescale 1ns/1ns
module analog_output_mode_and_diagnostics_tb;
	import aod_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [NUM_CH-1:0][7:0] mode = {4{8'h19}};
	logic [NUM_CH-1:0][15:0] word = '0;
	logic [NUM_CH-1:0] grp_en = 4'hf;
	logic irq_en = 1'b0;
	logic [NUM_CH-1:0] wbrk = '0;
	logic [NUM_CH-1:0] gshort = '0;
	logic [NUM_CH-1:0] fman = '0;
	logic sup_lost = 1'b0;
	logic cpu_stop = 1'b0;
	logic hold = 1'b1;
	logic rd_en, rd_rec, rd_valid, irq_done, irq, irq_going, led_group;
	logic [3:0] rd_addr;
	logic [7:0] rd_data;
	logic [NUM_CH-1:0][15:0] dac;
	logic [NUM_CH-1:0] cur, act, led_chan;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	always #2 mclk = ~mclk;
	aod_top dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_mode(mode),
		.i_out_word(word), .i_grp_diag_en(grp_en), .i_diag_irq_en(irq_en),
		.i_wire_break(wbrk), .i_gnd_short(gshort), .i_front_manual(fman),
		.i_supply_lost(sup_lost), .i_cpu_stop(cpu_stop), .i_rd_en(rd_en),
		.i_rd_rec(rd_rec), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid), .i_irq_done(irq_done), .o_irq(irq),
		.o_irq_going(irq_going), .o_dac_word(dac), .o_out_current(cur),
		.o_out_active(act), .o_led_group(led_group), .o_led_chan(led_chan));
	aod_host_model host (.i_mclk(mclk), .i_hold(hold), .i_irq(irq),
		.i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_rd_en(rd_en),
		.o_rd_rec(rd_rec), .o_rd_addr(rd_addr), .o_irq_done(irq_done));
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			$display("Error timeout expected end seen hang");
			results();
		end
	end
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdchk(input logic rec, input logic [3:0] a,
		input logic [7:0] exp, input logic [7:0] msk);
		logic [7:0] d;
		logic v;
		host.rd(rec, a, d, v);
		check("rd_valid", {15'h0, v}, 16'h1);
		check("rd_data", {8'h0, d & msk}, {8'h0, exp});
	endtask
	task automatic wait_irq(input logic lvl);
		for (int i = 0; i < 40; i++)
		begin
			@(posedge mclk);
			#1;
			if (irq === lvl)
				return;
		end
		check("irq_wait", {15'h0, irq}, {15'h0, lvl});
	endtask
	function automatic logic [15:0] lim(input logic [7:0] m,
		input logic [15:0] w);
		logic signed [15:0] lo;
		case (m)
			{TYPE_VOLT, RNG_V_0_10}, {TYPE_CURR, RNG_I_0_20}: lo = WORD_ZERO;
			{TYPE_VOLT, RNG_V_1_5}, {TYPE_CURR, RNG_I_4_20}:
				lo = WORD_UNDER_LIVE0;
			{TYPE_VOLT, RNG_V_BIP}, {TYPE_CURR, RNG_I_BIP}: lo = WORD_UNDER_BIP;
			default: return 16'h0000;
		endcase
		if ($signed(w) > WORD_OVER_END)
			return WORD_OVER_END;
		if ($signed(w) < lo)
			return lo;
		return w;
	endfunction
	task automatic t_reset();
		logic [12:0] tb [10] = '{{1'b0, 4'h0, 8'h00}, {1'b0, 4'h1, 8'h15},
			{1'b0, 4'h2, 8'h00}, {1'b0, 4'h3, 8'h00}, {1'b0, 4'h4, 8'h00},
			{1'b1, 4'h1, 8'h15}, {1'b1, 4'h4, 8'h73}, {1'b1, 4'h5, 8'h08},
			{1'b1, 4'h6, 8'h04}, {1'b1, 4'hc, 8'h00}};
		foreach (tb[i])
			rdchk(tb[i][12], tb[i][11:8], tb[i][7:0], 8'hff);
		$display("test reset done");
	endtask
	task automatic t_modes();
		logic [7:0] ml [8] = '{8'h18, 8'h17, 8'h19, 8'h22, 8'h23, 8'h24,
			8'h00, 8'h12};
		logic [15:0] wl [5] = '{16'h8000, 16'h7fff, 16'h6c00, 16'h9400,
			16'he4ff};
		foreach (ml[i])
			foreach (wl[j])
			begin
				@(posedge mclk);
				mode <= {NUM_CH{ml[i]}};
				word <= {NUM_CH{wl[j]}};
				repeat (2) @(posedge mclk);
				#1;
				for (int c = 0; c < NUM_CH; c++)
					check("dac", dac[c], lim(ml[i], wl[j]));
				check("act", {12'h0, act}, {12'h0, {4{i < 6}}});
				check("cur", {12'h0, cur}, {12'h0, {4{i > 2 && i < 6}}});
			end
		rdchk(1'b1, 4'h9, 8'h01, 8'hff);
		rdchk(1'b0, ADR_ERR, 8'h80, 8'h80);
		@(posedge mclk);
		mode <= {NUM_CH{8'h19}};
		$display("test modes done");
	endtask
	task automatic t_irq();
		@(posedge mclk);
		irq_en <= 1'b1;
		wbrk[1] <= 1'b1;
		wait_irq(1'b1);
		check("going", {15'h0, irq_going}, 16'h0);
		rdchk(1'b0, ADR_ERR, 8'h09, 8'h09);
		rdchk(1'b1, 4'h7, 8'h02, 8'hff);
		rdchk(1'b1, ADR_ERR, 8'h09, 8'h09);
		rdchk(1'b1, 4'h9, 8'h10, 8'hff);
		check("leds", {14'h0, led_group, led_chan[1]}, 16'h3);
		@(posedge mclk);
		wbrk[1] <= 1'b0;
		repeat (6) @(posedge mclk);
		rdchk(1'b1, 4'h9, 8'h10, 8'hff);
		check("irq_hold", {15'h0, irq}, 16'h1);
		@(posedge mclk);
		hold <= 1'b0;
		wait_irq(1'b0);
		wait_irq(1'b1);
		check("going", {15'h0, irq_going}, 16'h1);
		rdchk(1'b1, 4'h9, 8'h00, 8'hff);
		wait_irq(1'b0);
		$display("test interrupt done");
	endtask
	task automatic t_quiet();
		int hits;
		hits = 0;
		@(posedge mclk);
		irq_en <= 1'b0;
		gshort[2] <= 1'b1;
		grp_en[3] <= 1'b0;
		fman[3] <= 1'b1;
		repeat (8)
		begin
			@(posedge mclk);
			#1;
			if (irq !== 1'b0)
				hits++;
		end
		check("irq_quiet", hits[15:0], 16'h0);
		rdchk(1'b1, 4'ha, 8'h08, 8'hff);
		rdchk(1'b1, 4'hb, 8'h00, 8'hff);
		@(posedge mclk);
		grp_en[3] <= 1'b1;
		sup_lost <= 1'b1;
		cpu_stop <= 1'b1;
		repeat (5) @(posedge mclk);
		rdchk(1'b1, 4'hb, 8'h20, 8'hff);
		rdchk(1'b0, ADR_ERR, 8'h10, 8'h72);
		rdchk(1'b0, ADR_STATE, 8'h04, 8'hff);
		$display("test quiet done");
	endtask
	initial
	begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_modes();
		t_irq();
		t_quiet();
		results();
	end
endmodule // analog_output_mode_and_diagnostics_tb
